/* File: rtl/fbdiv_pkg.sv */
// Package for the feedback divider configuration block of the second PLL loop.
// Assumes byte-wide registers reached over a plain strobe port.
package fbdiv_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int DIV_W = 18;
    // Register offsets
    localparam logic [8:0] CAL_FEEDBACK_DIV_HIGH = 9'h163;
    localparam logic [8:0] CAL_FEEDBACK_DIV_MID = 9'h164;
    localparam logic [8:0] CAL_FEEDBACK_DIV_LOW = 9'h165;
    localparam logic [8:0] FEEDBACK_DIV_HIGH_AND_CAL_DISABLE = 9'h166;
    localparam logic [8:0] FEEDBACK_DIV_MID = 9'h167;
    localparam logic [8:0] FEEDBACK_DIV_LOW = 9'h168;
    // Field positions
    localparam int FREQ_CAL_DISABLE_BIT = 2;
    localparam int HIGH_FIELD_W = 2;
    // Reset values
    localparam logic [7:0] CAL_HIGH_RESET = 8'h00;
    localparam logic [7:0] CAL_MID_RESET = 8'h00;
    localparam logic [7:0] CAL_LOW_RESET = 8'h0C;
    localparam logic [7:0] FB_HIGH_RESET = 8'h00;
    localparam logic [7:0] FB_MID_RESET = 8'h00;
    localparam logic [7:0] FB_LOW_RESET = 8'h0C;
    localparam logic [17:0] CAL_DIV_RESET = 18'h0000C;
    localparam logic [17:0] FB_DIV_RESET = 18'h0000C;
    localparam logic [17:0] DIV_INVALID = 18'h00000;
    // Feedback source select value meaning cascaded zero-delay
    localparam logic FEEDBACK_SOURCE_CASCADED = 1'b1;
    // Masks for writable bits of the high registers
    localparam logic [7:0] CAL_HIGH_MASK = 8'h03;
    localparam logic [7:0] FB_HIGH_MASK = 8'h07;
endpackage : fbdiv_pkg

/* File: rtl/fbdiv_regs.sv */
// Byte register file for the two 18-bit divide values and the calibration disable bit.
// Assumes one write strobe per cycle from the owner of the configuration port.
`timescale 1ns/1ps
`default_nettype none
module fbdiv_regs
    import fbdiv_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [fbdiv_pkg::ADDR_W-1:0] addr,
    input wire logic [fbdiv_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [fbdiv_pkg::DATA_W-1:0] rdata,
    // Stored fields
    output logic [fbdiv_pkg::DIV_W-1:0] cal_shadow,
    output logic [fbdiv_pkg::DIV_W-1:0] fb_shadow,
    output logic freq_cal_disable,
    output logic low_written
);
    logic [7:0] cal_high, cal_mid, cal_low, fb_high, fb_mid, fb_low;
    logic [7:0] next_cal_high, next_cal_mid, next_cal_low;
    logic [7:0] next_fb_high, next_fb_mid, next_fb_low, next_rdata;

    // Register decode on write, read mux
    always_comb begin
        next_cal_high = cal_high;
        next_cal_mid = cal_mid;
        next_cal_low = cal_low;
        next_fb_high = fb_high;
        next_fb_mid = fb_mid;
        next_fb_low = fb_low;
        next_rdata = 8'h00;
        if (wr_en) begin
            case (addr)
                CAL_FEEDBACK_DIV_HIGH: next_cal_high = wdata & CAL_HIGH_MASK;
                CAL_FEEDBACK_DIV_MID: next_cal_mid = wdata;
                CAL_FEEDBACK_DIV_LOW: next_cal_low = wdata;
                FEEDBACK_DIV_HIGH_AND_CAL_DISABLE: next_fb_high = wdata & FB_HIGH_MASK;
                FEEDBACK_DIV_MID: next_fb_mid = wdata;
                FEEDBACK_DIV_LOW: next_fb_low = wdata;
                default: ;
            endcase
        end
        if (rd_en) begin
            case (addr)
                CAL_FEEDBACK_DIV_HIGH: next_rdata = cal_high;
                CAL_FEEDBACK_DIV_MID: next_rdata = cal_mid;
                CAL_FEEDBACK_DIV_LOW: next_rdata = cal_low;
                FEEDBACK_DIV_HIGH_AND_CAL_DISABLE: next_rdata = fb_high;
                FEEDBACK_DIV_MID: next_rdata = fb_mid;
                FEEDBACK_DIV_LOW: next_rdata = fb_low;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // Storage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_high <= CAL_HIGH_RESET;
            cal_mid <= CAL_MID_RESET;
            cal_low <= CAL_LOW_RESET;
            fb_high <= FB_HIGH_RESET;
            fb_mid <= FB_MID_RESET;
            fb_low <= FB_LOW_RESET;
            rdata <= 8'h00;
        end else begin
            cal_high <= next_cal_high;
            cal_mid <= next_cal_mid;
            cal_low <= next_cal_low;
            fb_high <= next_fb_high;
            fb_mid <= next_fb_mid;
            fb_low <= next_fb_low;
            rdata <= next_rdata;
        end
    end

    // Assembled words, seen by the core only on a low-byte write
    assign cal_shadow = {cal_high[HIGH_FIELD_W-1:0], cal_mid, cal_low};
    assign fb_shadow = {fb_high[HIGH_FIELD_W-1:0], fb_mid, fb_low};
    assign freq_cal_disable = fb_high[FREQ_CAL_DISABLE_BIT];
    assign low_written = wr_en && (addr == FEEDBACK_DIV_LOW);
endmodule : fbdiv_regs
`default_nettype wire

/* File: rtl/fbdiv_cal_seq.sv */
// Calibration sequencer: tracks a running VCO frequency calibration.
// Assumes the analog calibration engine pulses done when it finishes.
`timescale 1ns/1ps
`default_nettype none
module fbdiv_cal_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic start,
    input wire logic cal_done,
    // Status
    output logic cal_busy,
    output logic cal_start_pulse,
    output logic cal_finish_pulse
);
    typedef enum logic [0:0] {IDLE, RUN} cal_state_t;
    cal_state_t state, next_state;
    logic next_start_pulse, next_finish_pulse;

    // Next-state logic; a new start while running restarts the sequence
    always_comb begin
        next_state = state;
        next_start_pulse = 1'b0;
        next_finish_pulse = 1'b0;
        case (state)
            IDLE: begin
                if (start) begin
                    next_state = RUN;
                    next_start_pulse = 1'b1;
                end
            end
            RUN: begin
                if (start) begin
                    next_start_pulse = 1'b1;
                end else if (cal_done) begin
                    next_state = IDLE;
                    next_finish_pulse = 1'b1;
                end
            end
            default: next_state = IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= IDLE;
            cal_start_pulse <= 1'b0;
            cal_finish_pulse <= 1'b0;
        end else begin
            state <= next_state;
            cal_start_pulse <= next_start_pulse;
            cal_finish_pulse <= next_finish_pulse;
        end
    end

    assign cal_busy = (state == RUN);
endmodule : fbdiv_cal_seq
`default_nettype wire

/* File: rtl/pll_feedback_divider_config.sv */
// Feedback divider configuration for the second PLL loop: registers, calibration launch, divider select.
// Assumes a byte register port with read data one cycle after the read strobe.
//
// What this block does
// - No zero-delay feedback to the second loop while frequency calibration runs.
// - Hold 18-bit calibration divide value across three registers 0x163..0x165.
// - In cascaded mode, when calibration finishes, divider switches from calibration value to normal value.
// - Cascaded zero-delay mode means feedback source select equals one.
// - Hold 18-bit normal divide value in 0x166..0x168; code zero invalid.
// - Writing 0x168 starts frequency calibration when calibration disable reads zero.
// - Calibration disable is bit 2 of 0x166; when set, write only updates divider.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module pll_feedback_divider_config
    import fbdiv_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [fbdiv_pkg::ADDR_W-1:0] addr,
    input wire logic [fbdiv_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [fbdiv_pkg::DATA_W-1:0] rdata,
    // Mode and calibration engine
    input wire logic feedback_source_select,
    input wire logic zero_delay_request,
    input wire logic cal_done,
    output logic cal_start,
    output logic cal_busy,
    // Divider control
    output logic [fbdiv_pkg::DIV_W-1:0] active_divide,
    output logic cascaded_zero_delay,
    output logic zero_delay_enable,
    output logic divide_invalid
);
    import fbdiv_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [DIV_W-1:0] cal_shadow, fb_shadow;
    logic [DIV_W-1:0] cal_word, fb_word, next_cal_word, next_fb_word;
    logic [DIV_W-1:0] next_active_divide;
    logic freq_cal_disable, low_written, launch, finish_pulse, start_pulse;
    logic next_zero_delay_enable, next_divide_invalid, next_cascaded;

    fbdiv_regs u_regs (
        .clk(clk),
        .reset_n(reset_n),
        .addr(addr),
        .wdata(wdata),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .rdata(rdata),
        .cal_shadow(cal_shadow),
        .fb_shadow(fb_shadow),
        .freq_cal_disable(freq_cal_disable),
        .low_written(low_written)
    );

    // Launch only when the disable bit currently reads zero
    assign launch = low_written && !freq_cal_disable;

    fbdiv_cal_seq u_cal (
        .clk(clk),
        .reset_n(reset_n),
        .start(launch),
        .cal_done(cal_done),
        .cal_busy(cal_busy),
        .cal_start_pulse(start_pulse),
        .cal_finish_pulse(finish_pulse)
    );

    assign cal_start = start_pulse;

    ////////////////////////////////////////////////////////////////////////
    // Coherent words latched on the low-byte write of the normal divider
    always_comb begin
        next_cal_word = cal_word;
        next_fb_word = fb_word;
        if (low_written) begin
            next_fb_word = {fb_shadow[DIV_W-1:8], wdata};
            next_cal_word = cal_shadow;
        end
    end

    // Divider selection and zero-delay gating
    always_comb begin
        next_cascaded = (feedback_source_select == FEEDBACK_SOURCE_CASCADED);
        if (cal_busy && next_cascaded) begin
            next_active_divide = cal_word;
        end else begin
            next_active_divide = fb_word;
        end
        // Launch also gates, so zero delay drops in the same cycle that busy rises
        next_zero_delay_enable = zero_delay_request && !cal_busy && !launch;
        next_divide_invalid = (next_active_divide == DIV_INVALID);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_word <= CAL_DIV_RESET;
            fb_word <= FB_DIV_RESET;
            active_divide <= FB_DIV_RESET;
            cascaded_zero_delay <= 1'b0;
            zero_delay_enable <= 1'b0;
            divide_invalid <= 1'b0;
        end else begin
            cal_word <= next_cal_word;
            fb_word <= next_fb_word;
            active_divide <= next_active_divide;
            cascaded_zero_delay <= next_cascaded;
            zero_delay_enable <= next_zero_delay_enable;
            divide_invalid <= next_divide_invalid;
        end
    end
endmodule : pll_feedback_divider_config
`default_nettype wire

/* File: testbench/fbdiv_chk.sv */
// Checker for the feedback divider configuration block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module fbdiv_chk
    import fbdiv_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [fbdiv_pkg::ADDR_W-1:0] addr,
    input wire logic [fbdiv_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [fbdiv_pkg::DATA_W-1:0] rdata,
    // Mode, calibration and divider
    input wire logic feedback_source_select,
    input wire logic zero_delay_request,
    input wire logic cal_done,
    input wire logic cal_start,
    input wire logic cal_busy,
    input wire logic [fbdiv_pkg::DIV_W-1:0] active_divide,
    input wire logic cascaded_zero_delay,
    input wire logic zero_delay_enable,
    input wire logic divide_invalid
);
    logic dis, next_dis;
    logic [1:0] hi, next_hi;
    logic [7:0] mid, next_mid;
    logic [17:0] word, next_word;
    wire logic launch = wr_en && addr == FEEDBACK_DIV_LOW && !dis;
    ////////////////////////////////////////////////////////////////
    // Shadow of the disable bit and the committed normal word
    always_comb begin
        next_dis = dis;
        next_hi = hi;
        next_mid = mid;
        next_word = word;
        if (wr_en && addr == FEEDBACK_DIV_HIGH_AND_CAL_DISABLE) begin
            next_dis = wdata[FREQ_CAL_DISABLE_BIT];
            next_hi = wdata[1:0];
        end
        if (wr_en && addr == FEEDBACK_DIV_MID) next_mid = wdata;
        if (wr_en && addr == FEEDBACK_DIV_LOW) next_word = {hi, mid, wdata};
    end
    // Register the shadow
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dis <= 1'b0;
            hi <= 2'h0;
            mid <= 8'h00;
            word <= FB_DIV_RESET;
        end else begin
            dis <= next_dis;
            hi <= next_hi;
            mid <= next_mid;
            word <= next_word;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_zd_gated: assert property (cal_busy |=> !zero_delay_enable)
        else $error("zero delay enabled during calibration");
    a_zd_follow: assert property (zero_delay_request && !cal_busy && !launch |=> zero_delay_enable)
        else $error("zero delay not enabled when idle");
    a_zd_exclusive: assert property (!(cal_busy && zero_delay_enable))
        else $error("zero delay enabled while calibration busy");
    a_cascade_track: assert property (1'b1 |=> cascaded_zero_delay == $past(feedback_source_select))
        else $error("cascaded mode does not follow source select");
    a_cal_launch: assert property (launch |=> cal_start && cal_busy)
        else $error("calibration not launched");
    a_no_launch: assert property (!launch |=> !cal_start)
        else $error("calibration started without launch");
    a_busy_end: assert property (cal_busy && cal_done && !launch |=> !cal_busy)
        else $error("busy stays after done");
    a_switch_normal: assert property ($fell(cal_busy) |=> active_divide == word)
        else $error("normal word not applied after calibration");
    a_invalid_flag: assert property (divide_invalid == (active_divide == DIV_INVALID))
        else $error("invalid flag wrong");
    a_read_idle: assert property (!rd_en |=> rdata == 8'h00)
        else $error("read data outside read cycle");
    c_launch: cover property (launch);
    c_finish: cover property ($fell(cal_busy));
    c_disabled: cover property (wr_en && addr == FEEDBACK_DIV_LOW && dis);
endmodule : fbdiv_chk
bind pll_feedback_divider_config fbdiv_chk u_chk (.clk, .reset_n, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .feedback_source_select, .zero_delay_request, .cal_done, .cal_start, .cal_busy, .active_divide,
    .cascaded_zero_delay, .zero_delay_enable, .divide_invalid);
`default_nettype wire

/* File: testbench/tb_pll_feedback_divider_config.sv */
// Testbench for the feedback divider configuration block.
// Assumes a 40 MHz clock and the byte register port of the design.
`timescale 1ns/1ps
`default_nettype none
module tb_pll_feedback_divider_config;
    import fbdiv_pkg::*;
    logic clk = 0, reset_n = 0, wr_en = 0, rd_en = 0, fss = 1, zdr = 1, cal_done = 0;
    logic [8:0] addr = 9'h000;
    logic [7:0] wdata = 8'h00, rdata;
    logic cal_start, cal_busy, czd, zde, inv;
    logic [17:0] adiv;
    int n_fail = 0, cmp_count = 0;
    // Rows: address, write data, expected read back
    logic [24:0] rows [6] = '{{9'h163, 8'hFF, 8'h03}, {9'h164, 8'hA5, 8'hA5}, {9'h165, 8'h5A, 8'h5A},
        {9'h166, 8'hF9, 8'h01}, {9'h167, 8'h3C, 8'h3C}, {9'h169, 8'h77, 8'h00}};
    pll_feedback_divider_config uut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .feedback_source_select(fss),
        .zero_delay_request(zdr), .cal_done(cal_done), .cal_start(cal_start), .cal_busy(cal_busy),
        .active_divide(adiv), .cascaded_zero_delay(czd), .zero_delay_enable(zde), .divide_invalid(inv));
    // Clock
    always #12.5 clk = ~clk;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(rdata, e);
    endtask : rd
    task automatic complete_run;
        if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        chk(adiv, FB_DIV_RESET);
        for (int i = 0; i < 6; i++) rd(9'h163 + 9'(i), (i % 3 == 2) ? 8'h0C : 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][24:16], rows[i][15:8]);
            rd(rows[i][24:16], rows[i][7:0]);
        end
        wr(FEEDBACK_DIV_LOW, 8'hC3);
        chk({cal_start, cal_busy, czd}, 3'b111);
        chk(zde, 1'b0);
        @(posedge clk) #1 chk(adiv, 18'h3A55A);
        chk(zde, 1'b0);
        @(posedge clk) cal_done <= 1'b1;
        @(posedge clk) cal_done <= 1'b0;
        #1 chk(cal_busy, 1'b0);
        @(posedge clk) #1 chk(adiv, 18'h13CC3);
        chk(zde, 1'b1);
        fss <= 1'b0;
        wr(FEEDBACK_DIV_HIGH_AND_CAL_DISABLE, 8'h04);
        wr(FEEDBACK_DIV_MID, 8'h00);
        wr(FEEDBACK_DIV_LOW, 8'h00);
        chk({cal_start, cal_busy, czd}, 3'b000);
        @(posedge clk) #1 chk({adiv, inv}, 19'h00001);
        rd(FEEDBACK_DIV_HIGH_AND_CAL_DISABLE, 8'h04);
        complete_run();
    end
    // Watchdog
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule : tb_pll_feedback_divider_config
`default_nettype wire
